// *** core/mecd_pkg.sv ***
// shared constants and carrier types for the memory ecc diagnostic control block
package mecd_pkg;

  // register map
  localparam logic [31:0] MECD_DIAG_REG_ADDR   = 32'h1008_0144;
  localparam int          MECD_CRD_IE_BIT      = 12;
  localparam int          MECD_FORCE_REF_BIT   = 11;
  localparam int          MECD_DETECT_DIS_BIT  = 10;
  localparam int          MECD_DIAG_MODE_BIT   = 7;
  localparam int          MECD_CHECK_MSB       = 6;
  localparam logic [31:0] MECD_DIAG_REG_RESET  = 32'h0000_0000;
  // writable bits; 31:13 and 9:8 always read zero
  localparam logic [31:0] MECD_DIAG_WR_MASK    = 32'h0000_1cff;

  // code geometry
  localparam int          MECD_DATA_W          = 32;
  localparam int          MECD_CHECK_W         = 7;

  // special syndromes
  localparam logic [6:0]  MECD_SYN_NONE        = 7'h00;
  localparam logic [6:0]  MECD_SYN_PARITY_SIG  = 7'h07;
  // low check bits inverted on a bus parity error
  localparam logic [6:0]  MECD_PARITY_FLIP     = 7'h07;

  // syndrome of each single data-bit error, index is the data bit
  localparam logic [6:0] MECD_DATA_SYN [32] = '{
    7'h58, 7'h1c, 7'h1a, 7'h5e, 7'h1f, 7'h5b, 7'h5d, 7'h19,
    7'h68, 7'h2c, 7'h2a, 7'h6e, 7'h2f, 7'h6b, 7'h6d, 7'h29,
    7'h70, 7'h34, 7'h32, 7'h76, 7'h37, 7'h73, 7'h75, 7'h31,
    7'h38, 7'h7c, 7'h7a, 7'h3e, 7'h7f, 7'h3b, 7'h3d, 7'h79
  };

  // corrected-error interrupt identity
  localparam logic [4:0]  MECD_CRD_INT_LEVEL   = 5'h1a;
  localparam logic [7:0]  MECD_CRD_INT_VECTOR  = 8'h54;

  // refresh timing
  localparam int          MECD_CLK_PERIOD_PS   = 20000;
  localparam int          MECD_REFRESH_PS      = 11300000;
  localparam int          MECD_REFRESH_CYCLES  = MECD_REFRESH_PS / MECD_CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    MECD_REF_IDLE = 2'b01,
    MECD_REF_BUSY = 2'b10
  } mecd_ref_state_type;

  // word as it sits in the array
  typedef struct packed {
    logic [31:0] data;
    logic [6:0]  check;
  } mecd_mem_word_type;

  // outcome of one checked read
  typedef struct packed {
    logic [31:0] data;
    logic [6:0]  syndrome;
    logic        single_data;
    logic        single_check;
    logic        multi;
    logic        parity_sig;
  } mecd_read_result_type;

endpackage : mecd_pkg

// *** core/mecd_ctrl.sv ***
// memory ecc generation, syndrome decode, diagnostic register and refresh pacing
`timescale 1ns/1ps

module mecd_ctrl #(
  parameter int DATA_W  = mecd_pkg::MECD_DATA_W,
  parameter int CHECK_W = mecd_pkg::MECD_CHECK_W
) (
  // clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           reset,
  input  wire logic                           dc_power_good,
  input  wire logic                           cpu_halted,
  // register access from the cpu data/address bus
  input  wire logic [31:0]                    cpu_addr,
  input  wire logic                           cpu_wr,
  input  wire logic                           cpu_rd,
  input  wire logic [31:0]                    cpu_wdata,
  output logic      [31:0]                    cpu_rdata,
  output logic                                cpu_ack,
  // memory write path
  input  wire logic                           wr_req,
  input  wire logic [31:0]                    wr_data,
  input  wire logic                           wr_parity_err,
  output mecd_pkg::mecd_mem_word_type         wr_word,
  output logic                                wr_word_valid,
  // memory read path
  input  wire logic                           rd_valid,
  input  wire mecd_pkg::mecd_mem_word_type    rd_word,
  output mecd_pkg::mecd_read_result_type      rd_result,
  output logic                                rd_result_valid,
  // corrected-error interrupt to the diagnostic processor
  output logic                                crd_int_req,
  output logic      [4:0]                     interrupt_priority_level,
  output logic      [7:0]                     crd_int_vector,
  // refresh handshake with the array sequencer
  output logic                                refresh_req,
  input  wire logic                           refresh_done
);

  if (DATA_W != mecd_pkg::MECD_DATA_W || CHECK_W != mecd_pkg::MECD_CHECK_W) begin : g_chk
    $error("mecd_ctrl: syndrome table serves only 32 data and 7 check bits");
  end

  // generator: check bit j covers every data bit whose syndrome has bit j set
  function automatic logic [6:0] gen_check(input logic [31:0] d);
    logic [6:0] c;
    c = '0;
    for (int i = 0; i < 32; i++) begin
      if (d[i]) begin
        c = c ^ mecd_pkg::MECD_DATA_SYN[i];
      end
    end
    return c;
  endfunction : gen_check

  // decode a syndrome into a data-bit flip mask
  function automatic logic [31:0] data_flip(input logic [6:0] s);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 32; i++) begin
      m[i] = (s == mecd_pkg::MECD_DATA_SYN[i]);
    end
    return m;
  endfunction : data_flip

  logic                       clear_all;
  logic                       reg_hit;
  logic [31:0]                diag_reg;
  logic                       crd_ie;
  logic                       force_ref;
  logic                       detect_dis;
  logic                       diag_mode;
  logic [6:0]                 check_field;
  logic                       wr_hit;
  logic                       force_set;
  logic                       read_capture;
  logic [6:0]                 syn;
  logic [31:0]                flip;
  logic                       one_hot_syn;
  logic                       single_data;
  logic [6:0]                 gen_wr;
  logic [9:0]                 ref_cnt_reg;
  logic                       ref_tick;
  logic                       ref_owner_force_reg;
  mecd_pkg::mecd_ref_state_type ref_state_reg;

  // power-good loss while halted behaves as a reset of the block
  assign clear_all = reset | (~dc_power_good & cpu_halted);
  assign reg_hit   = (cpu_addr == mecd_pkg::MECD_DIAG_REG_ADDR);
  assign wr_hit    = cpu_wr & reg_hit;
  assign force_set = wr_hit & cpu_wdata[mecd_pkg::MECD_FORCE_REF_BIT];

  assign crd_ie      = diag_reg[mecd_pkg::MECD_CRD_IE_BIT];
  assign force_ref   = diag_reg[mecd_pkg::MECD_FORCE_REF_BIT];
  assign detect_dis  = diag_reg[mecd_pkg::MECD_DETECT_DIS_BIT];
  assign diag_mode   = diag_reg[mecd_pkg::MECD_DIAG_MODE_BIT];
  assign check_field = diag_reg[mecd_pkg::MECD_CHECK_MSB:0];

  // ---------------- control register ----------------
  assign read_capture = rd_valid & ~diag_mode;

  always_ff @(posedge sys_clk) begin
    if (clear_all) begin
      diag_reg <= mecd_pkg::MECD_DIAG_REG_RESET;
    end else begin
      if (wr_hit) begin
        // unused bits are never stored so they always read zero
        diag_reg <= cpu_wdata & mecd_pkg::MECD_DIAG_WR_MASK;
      end
      // a captured read beats a software write of the field in the same cycle
      if (read_capture) begin
        diag_reg[mecd_pkg::MECD_CHECK_MSB:0] <= rd_word.check;
      end
      // hardware clear on completion only if software is not setting it again
      if (refresh_done && ref_owner_force_reg && !force_set) begin
        diag_reg[mecd_pkg::MECD_FORCE_REF_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clear_all) begin
      cpu_rdata <= '0;
      cpu_ack   <= 1'b0;
    end else begin
      cpu_ack <= (cpu_rd | cpu_wr) & reg_hit;
      if (cpu_rd && reg_hit) begin
        cpu_rdata <= diag_reg & mecd_pkg::MECD_DIAG_WR_MASK;
      end
    end
  end

  // ---------------- write path ----------------
  always_comb begin
    gen_wr = gen_check(wr_data);
    if (wr_parity_err) begin
      gen_wr = gen_wr ^ mecd_pkg::MECD_PARITY_FLIP;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clear_all) begin
      wr_word       <= '0;
      wr_word_valid <= 1'b0;
    end else begin
      wr_word_valid <= wr_req;
      if (wr_req) begin
        wr_word.data <= wr_data;
        // substitution wins even over the parity corruption
        wr_word.check <= diag_mode ? check_field : gen_wr;
      end
    end
  end

  // ---------------- read path ----------------
  assign syn         = rd_word.check ^ gen_check(rd_word.data);
  assign flip        = data_flip(syn);
  assign single_data = |flip;
  assign one_hot_syn = (syn != mecd_pkg::MECD_SYN_NONE) && ((syn & (syn - 7'h01)) == 7'h00);

  always_ff @(posedge sys_clk) begin
    if (clear_all) begin
      rd_result       <= '0;
      rd_result_valid <= 1'b0;
    end else begin
      rd_result_valid <= rd_valid;
      if (rd_valid) begin
        if (detect_dis) begin
          // raw data passes untouched and nothing is flagged
          rd_result      <= '0;
          rd_result.data <= rd_word.data;
        end else begin
          rd_result.data         <= rd_word.data ^ flip;
          rd_result.syndrome     <= syn;
          rd_result.single_data  <= single_data;
          rd_result.single_check <= one_hot_syn;
          rd_result.parity_sig   <= (syn == mecd_pkg::MECD_SYN_PARITY_SIG);
          // parity signature has three bits set, so it also lands here
          rd_result.multi <= (syn != mecd_pkg::MECD_SYN_NONE) && !single_data
                             && !one_hot_syn;
        end
      end
    end
  end

  // ---------------- corrected-error interrupt ----------------
  // gates only the interrupt; rd_result reports regardless of crd_ie
  always_ff @(posedge sys_clk) begin
    if (clear_all) begin
      crd_int_req <= 1'b0;
    end else begin
      crd_int_req <= rd_valid & ~detect_dis & crd_ie
                     & (single_data | one_hot_syn);
    end
  end

  assign interrupt_priority_level = mecd_pkg::MECD_CRD_INT_LEVEL;
  assign crd_int_vector           = mecd_pkg::MECD_CRD_INT_VECTOR;

  // ---------------- refresh pacing ----------------
  localparam logic [9:0] REF_LAST = 10'(mecd_pkg::MECD_REFRESH_CYCLES - 1);

  always_ff @(posedge sys_clk) begin
    if (clear_all) begin
      ref_cnt_reg <= '0;
    end else if (ref_tick) begin
      ref_cnt_reg <= '0;
    end else begin
      ref_cnt_reg <= ref_cnt_reg + 10'h001;
    end
  end

  // the periodic tick fires every MECD_REFRESH_CYCLES cycles, even while a forced refresh is being tested
  assign ref_tick = (ref_cnt_reg == REF_LAST);

  always_ff @(posedge sys_clk) begin
    if (clear_all) begin
      ref_state_reg       <= mecd_pkg::MECD_REF_IDLE;
      ref_owner_force_reg <= 1'b0;
    end else begin
      unique case (ref_state_reg)
        mecd_pkg::MECD_REF_IDLE: begin
          // a bit set while busy is still owed its refresh, else it would stick forever
          if (force_set || force_ref) begin
            ref_state_reg       <= mecd_pkg::MECD_REF_BUSY;
            ref_owner_force_reg <= 1'b1;
          end else if (ref_tick && !force_ref) begin
            ref_state_reg       <= mecd_pkg::MECD_REF_BUSY;
            ref_owner_force_reg <= 1'b0;
          end
        end
        mecd_pkg::MECD_REF_BUSY: begin
          if (refresh_done) begin
            ref_state_reg <= mecd_pkg::MECD_REF_IDLE;
          end
        end
        default: begin
          ref_state_reg <= mecd_pkg::MECD_REF_IDLE;
        end
      endcase
    end
  end

  assign refresh_req = (ref_state_reg == mecd_pkg::MECD_REF_BUSY);

endmodule : mecd_ctrl

// *** testbench/mecd_ctrl_props.sv ***
// concurrent checks on the ecc diagnostic control block ports
`timescale 1ns/1ps
module mecd_ctrl_chk (
  // clock and reset
  input wire logic                           sys_clk,
  input wire logic                           reset,
  input wire logic                           dc_power_good,
  input wire logic                           cpu_halted,
  // register bus
  input wire logic [31:0]                    cpu_addr,
  input wire logic                           cpu_wr,
  input wire logic                           cpu_rd,
  input wire logic [31:0]                    cpu_rdata,
  input wire logic                           cpu_ack,
  // data paths
  input wire logic                           rd_valid,
  input wire mecd_pkg::mecd_read_result_type rd_result,
  input wire logic                           rd_result_valid,
  input wire logic                           crd_int_req,
  input wire logic [4:0]                     interrupt_priority_level,
  input wire logic [7:0]                     crd_int_vector,
  // refresh
  input wire logic                           refresh_req,
  input wire logic                           refresh_done
);
  // power-good loss while halted clears like reset but is not a disable
  wire clr = !dc_power_good && cpu_halted;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_hit;
    (cpu_wr || cpu_rd) && cpu_addr == 32'h1008_0144 && !clr;
  endsequence
  sequence s_idle;
    !refresh_req && !cpu_ack && !rd_result_valid && !crd_int_req;
  endsequence
  property p_ack; s_hit |=> cpu_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack for register access");
  property p_unused; cpu_rdata[31:13] == 19'h0 && cpu_rdata[9:8] == 2'h0; endproperty
  a_unused: assert property (p_unused) else $error("unused bits nonzero");
  property p_clear; clr |=> s_idle; endproperty
  a_clear: assert property (p_clear) else $error("outputs not cleared");
  property p_req_hold; refresh_req && !refresh_done && !clr |=> refresh_req; endproperty
  a_req_hold: assert property (p_req_hold) else $error("refresh request dropped");
  property p_req_end; refresh_req && refresh_done |=> !refresh_req; endproperty
  a_req_end: assert property (p_req_end) else $error("refresh request stuck");
  property p_rd; rd_valid && !clr |=> rd_result_valid; endproperty
  a_rd: assert property (p_rd) else $error("read result missing");
  property p_int;
    crd_int_req |-> rd_result_valid && !rd_result.multi &&
      (rd_result.single_data || rd_result.single_check);
  endproperty
  a_int: assert property (p_int) else $error("interrupt without corrected error");
  property p_ident; interrupt_priority_level == 5'h1a && crd_int_vector == 8'h54; endproperty
  a_ident: assert property (p_ident) else $error("wrong interrupt level or vector");
  property p_none;
    rd_result_valid && rd_result.syndrome == 7'h00 |-> !(rd_result.multi ||
      rd_result.single_data || rd_result.single_check || rd_result.parity_sig);
  endproperty
  a_none: assert property (p_none) else $error("flags on zero syndrome");
  property p_check;
    rd_result_valid && $onehot(rd_result.syndrome) |-> rd_result.single_check;
  endproperty
  a_check: assert property (p_check) else $error("check-bit error not flagged");
  property p_par;
    rd_result_valid && rd_result.syndrome == 7'h07 |-> rd_result.parity_sig;
  endproperty
  a_par: assert property (p_par) else $error("parity signature missed");
endmodule : mecd_ctrl_chk

bind mecd_ctrl mecd_ctrl_chk u_chk (.sys_clk, .reset, .dc_power_good, .cpu_halted,
  .cpu_addr, .cpu_wr, .cpu_rd, .cpu_rdata, .cpu_ack, .rd_valid, .rd_result, .rd_result_valid,
  .crd_int_req, .interrupt_priority_level, .crd_int_vector, .refresh_req, .refresh_done);

// *** testbench/mecd_seq_model.sv ***
// array sequencer model answering refresh requests after a set latency
`timescale 1ns/1ps
module mecd_seq_model (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       reset,
  // refresh handshake
  input wire logic       refresh_req,
  input wire logic [3:0] lat,
  output logic           refresh_done
);
  logic [3:0] cnt_reg;
  // done only while a request stands, one pulse each
  always_ff @(posedge sys_clk) begin
    if (reset || !refresh_req || refresh_done) begin
      cnt_reg      <= 4'h0;
      refresh_done <= 1'b0;
    end else begin
      cnt_reg      <= cnt_reg + 4'h1;
      refresh_done <= (cnt_reg == lat);
    end
  end
endmodule : mecd_seq_model

// *** testbench/tb.sv ***
// self-checking bench for the ecc diagnostic control block
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] RA = mecd_pkg::MECD_DIAG_REG_ADDR;
  logic sys_clk, reset, dc_power_good, cpu_halted, cpu_wr, cpu_rd, cpu_ack, wr_req;
  logic wr_parity_err, wr_word_valid, rd_valid, rd_result_valid, crd_int_req;
  logic refresh_req, refresh_done, en, dis, pe, sd, sc;
  logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, wr_data, d, cd;
  logic [4:0] interrupt_priority_level;
  logic [7:0] crd_int_vector;
  logic [6:0] syn;
  logic [3:0] lat;
  logic [46:0] act;
  logic [46:0] expq[$];
  mecd_pkg::mecd_mem_word_type wr_word, rd_word, w;
  mecd_pkg::mecd_read_result_type rd_result, r;
  int fails = 0, n_compared = 0, cyc = 0, seed, t, sel;
  mecd_ctrl dut (.sys_clk, .reset, .dc_power_good, .cpu_halted, .cpu_addr, .cpu_wr, .cpu_rd,
    .cpu_wdata, .cpu_rdata, .cpu_ack, .wr_req, .wr_data, .wr_parity_err, .wr_word,
    .wr_word_valid, .rd_valid, .rd_word, .rd_result, .rd_result_valid, .crd_int_req,
    .interrupt_priority_level, .crd_int_vector, .refresh_req, .refresh_done);
  mecd_seq_model u_seq (.sys_clk, .reset, .refresh_req, .lat, .refresh_done);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, cyc, 20000);
      tally_and_finish();
    end
  end
  function automatic logic [6:0] gen(input logic [31:0] x);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 0; i < 32; i++) if (x[i]) c = c ^ mecd_pkg::MECD_DATA_SYN[i];
    return c;
  endfunction : gen
  // unmapped accesses expect nothing, so a stray ack shows up as unexpected
  task automatic reg_acc(input logic wr, input logic [31:0] a, input logic [31:0] v);
    @(negedge sys_clk);
    {cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = {wr, !wr, a, v};
    if (a == RA) expq.push_back(wr ? {2'd3, 45'h0} : {2'd0, 13'h0, v});
    @(negedge sys_clk);
    {cpu_wr, cpu_rd} = 2'b00;
  endtask : reg_acc
  task automatic mem_wr(input logic [31:0] x, input logic p, input logic [6:0] c);
    @(negedge sys_clk);
    {wr_req, wr_data, wr_parity_err} = {1'b1, x, p};
    expq.push_back({2'd1, 6'h0, x, c});
    @(negedge sys_clk);
    wr_req = 1'b0;
  endtask : mem_wr
  task automatic mem_rd(input mecd_pkg::mecd_mem_word_type m, input logic [46:0] e);
    @(negedge sys_clk);
    {rd_valid, rd_word} = {1'b1, m};
    expq.push_back(e);
    @(negedge sys_clk);
    rd_valid = 1'b0;
  endtask : mem_rd
  always @(negedge sys_clk) begin
    if (rd_result_valid || wr_word_valid || cpu_ack) begin
      if (rd_result_valid) act = {2'd2, 1'b0, crd_int_req, rd_result};
      else if (wr_word_valid) act = {2'd1, 6'h0, wr_word};
      else act = {2'd0, 13'h0, cpu_rdata};
      if (expq.size() == 0) begin
        fails++;
        $display("BAD %0t got %h exp none", $time, act);
      end else begin
        n_compared++;
        if (expq[0][46:45] == 2'd3 && act[46:45] == 2'd0) act = expq[0];
        if (act !== expq[0]) begin
          fails++;
          $display("BAD %0t got %h exp %h", $time, act, expq[0]);
        end
        void'(expq.pop_front());
      end
    end
  end
  initial begin
    seed = 32'h3092;
    {reset, dc_power_good, cpu_halted, lat} = {1'b1, 1'b1, 1'b0, 4'h0};
    {cpu_wr, cpu_rd, wr_req, wr_parity_err, rd_valid} = 5'h00;
    {cpu_addr, cpu_wdata, wr_data, rd_word} = '0;
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    reg_acc(1'b0, RA, 32'h0);
    t = 0;
    while (!refresh_req && t < 2000) begin @(negedge sys_clk); t++; end
    t = 0;
    do begin @(negedge sys_clk); t++; end while (refresh_req && t < 2000);
    while (!refresh_req && t < 2000) begin @(negedge sys_clk); t++; end
    n_compared++;
    if (t != mecd_pkg::MECD_REFRESH_CYCLES) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, t, mecd_pkg::MECD_REFRESH_CYCLES);
    end
    reg_acc(1'b1, RA, 32'hffff_f7ff);
    reg_acc(1'b1, RA + 32'h4, 32'h0);
    reg_acc(1'b0, RA, 32'h0000_14ff);
    mem_wr($random(seed), 1'b1, 7'h7f);
    w = '{32'h0000_0005, 7'h00};
    mem_rd(w, {2'd2, 1'b0, 1'b0, w.data, 11'h000});
    @(negedge sys_clk) dc_power_good = 1'b0;
    reg_acc(1'b0, RA, 32'h0000_14ff);
    cpu_halted = 1'b1;
    @(negedge sys_clk) {dc_power_good, cpu_halted} = 2'b10;
    reg_acc(1'b0, RA, 32'h0);
    lat = 4'h5;
    reg_acc(1'b1, RA, 32'h0000_0800);
    reg_acc(1'b0, RA, 32'h0000_0800);
    t = 0;
    while (refresh_req && t < 100) begin @(negedge sys_clk); t++; end
    n_compared++;
    if (t != lat) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, t, lat);
    end
    reg_acc(1'b0, RA, 32'h0);
    for (int k = 0; k < 24; k++) begin
      {en, dis} = {k[0], k % 4 == 3};
      reg_acc(1'b1, RA, {19'h0, en, 1'b0, dis, 10'h0});
      d = $random(seed);
      pe = 1'($random(seed));
      mem_wr(d, pe, gen(d) ^ (pe ? 7'h07 : 7'h00));
      w = '{d, gen(d)};
      sel = k % 6 == 0 ? 39 : k % 6 == 1 ? 32 + k % 7 : k % 6 == 2 ? 41 : k % 6 == 3 ? 40
        : $unsigned($random(seed)) % 32;
      if (sel < 32) w.data[sel] = ~w.data[sel];
      else if (sel < 39) w.check[sel-32] = ~w.check[sel-32];
      else if (sel == 39) w.check = w.check ^ 7'h07;
      else if (sel == 40) w.data[1:0] = ~w.data[1:0];
      syn = w.check ^ gen(w.data);
      {cd, sd, sc} = {w.data, 1'b0, $onehot(syn)};
      for (int i = 0; i < 32; i++) begin
        if (syn == mecd_pkg::MECD_DATA_SYN[i]) {sd, cd[i]} = {1'b1, ~cd[i]};
      end
      r = dis ? '{w.data, 7'h0, 1'b0, 1'b0, 1'b0, 1'b0}
        : '{cd, syn, sd, sc, syn != 7'h0 && !sd && !sc, syn == 7'h07};
      mem_rd(w, {2'd2, 1'b0, en & !dis & (sd | sc), r});
      if (!dis) reg_acc(1'b0, RA, {19'h0, en, 5'h0, w.check});
    end
    repeat (3) @(negedge sys_clk);
    if (expq.size() != 0) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, expq.size(), 0);
    end
    tally_and_finish();
  end
endmodule : tb
